/* File: verilog/ssm_pkg.sv */
// Package of constants for the slot switch memory programming block.
// Assumes a 32-bit APB register bus and 8-bit slot addresses.

package ssm_pkg;

  // ********************************************************************
  // Register byte offsets
  // ********************************************************************
  localparam logic [7:0] OFS_DATA   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_CMD    = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_MODE   = 8'h10;

  // ********************************************************************
  // Reset values and field positions
  // ********************************************************************
  localparam logic [7:0] MODE_RESET    = 8'h00;
  localparam logic [7:0] DATA_RESET    = 8'h00;
  localparam logic [7:0] ADDR_RESET    = 8'h00;
  localparam int         STATUS_BUSY   = 0;
  localparam int         CFI_PORT_LSB  = 1;
  localparam int         CODE_W        = 4;
  localparam int         PTR_W         = 8;

  // ********************************************************************
  // Commands written to the command register
  // ********************************************************************
  localparam logic [7:0] CMD_DATA_ONLY = 8'h48;
  localparam logic [7:0] CMD_TRISTATE  = 8'h60;
  localparam logic [7:0] CMD_READ_DATA = 8'hC8;
  localparam logic [7:0] CMD_READ_CODE = 8'hF0;
  localparam logic [3:0] CMD_SWITCH_HI = 4'h7;

  // ********************************************************************
  // Code field values and subslot masks
  // ********************************************************************
  localparam logic [3:0] CODE_UNASSIGNED = 4'h0;
  localparam logic [3:0] CODE_FULL       = 4'h1;
  localparam logic [7:0] MASK_FULL       = 8'hFF;
  localparam logic [7:0] MASK_NIBBLE     = 8'h0F;
  localparam logic [7:0] MASK_PAIR       = 8'h03;

endpackage

/* File: verilog/ssm_ctrl_mem.sv */
// Two-port memory with a masked host port and a frame read port.
// Both reads are registered; the caller gates ports with the clock enable.

`timescale 1ns/100ps
`default_nettype none

module ssm_ctrl_mem #(
  parameter int ADDR_W = 8,
  parameter int WORD_W = 12
) (
  input  wire logic              clk,
  input  wire logic              host_en,
  input  wire logic              host_we,
  input  wire logic [WORD_W-1:0] host_wmask,
  input  wire logic [ADDR_W-1:0] host_addr,
  input  wire logic [WORD_W-1:0] host_wdata,
  output var  logic [WORD_W-1:0] host_rdata,
  input  wire logic              frame_en,
  input  wire logic [ADDR_W-1:0] frame_addr,
  output var  logic [WORD_W-1:0] frame_rdata
);

  // ********************************************************************
  // Storage
  // ********************************************************************
  logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];

  if (ADDR_W < 1 || ADDR_W > 12 || WORD_W < 1) begin : g_check
    $error("ssm_ctrl_mem: unsupported size");
  end

  // Host port, masked write keeps the untouched field intact
  always_ff @(posedge clk) begin
    if (host_en) begin
      if (host_we) begin
        mem[host_addr] <= (mem[host_addr] & ~host_wmask) | (host_wdata & host_wmask);
      end
      host_rdata <= mem[host_addr];
    end
  end

  // Frame read port
  always_ff @(posedge clk) begin
    if (frame_en) begin
      frame_rdata <= mem[frame_addr];
    end
  end

endmodule

`default_nettype wire

/* File: verilog/ssm_subslot_map.sv */
// Moves the selected PCM subslot bits to the CONFIGURABLE_SERIAL_INTERFACE subslot position.
// Purely combinational; the caller registers the results.

`timescale 1ns/100ps
`default_nettype none

module ssm_subslot_map (
  input  wire logic [3:0] code,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] pcm_byte,
  output logic      [7:0] cfi_byte,
  output logic      [7:0] cfi_mask,
  output logic      [7:0] pcm_mask,
  output logic            switched
);

  // ********************************************************************
  // Bandwidth and position decode
  // ********************************************************************
  logic [2:0] pcm_sh;
  logic [2:0] cfi_sh;
  logic [7:0] width_mask;

  always_comb begin
    pcm_sh     = 3'h0;
    cfi_sh     = 3'h0;
    width_mask = 8'h00;
    if (code == ssm_pkg::CODE_FULL) begin
      width_mask = ssm_pkg::MASK_FULL;
    end else if (code[3:1] == 3'b001) begin
      width_mask = ssm_pkg::MASK_NIBBLE;
      pcm_sh     = code[0] ? 3'h4 : 3'h0;
      cfi_sh     = mode[0] ? 3'h0 : 3'h4;
    end else if (code[3:2] == 2'b01) begin
      width_mask = ssm_pkg::MASK_PAIR;
      pcm_sh     = {code[1:0], 1'b0};
      cfi_sh     = {~mode, 1'b0};
    end
  end

  always_comb begin
    pcm_mask = width_mask << pcm_sh;
    cfi_mask = width_mask << cfi_sh;
    cfi_byte = ((pcm_byte >> pcm_sh) & width_mask) << cfi_sh;
  end

  assign switched = (code[3] == 1'b0) && (code != ssm_pkg::CODE_UNASSIGNED);

endmodule

`default_nettype wire

/* File: verilog/ssm_top.sv */
// Control memory programming and subchannel selection of a slot switch.
// Assumes an APB master on CLK and a frame sequencer that presents slots.
//
// Chosen here: the address map and the APB register port.

`timescale 1ns/100ps
`default_nettype none

module ssm_top #(
  parameter int SLOT_W = 8
) (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SLOT_STROBE,
  input  wire logic [7:0]  SLOT_CFI_ADDR,
  input  wire logic [7:0]  PCM_SAMPLE,
  output logic             SLOT_VALID,
  output logic             SLOT_SWITCHED,
  output logic      [7:0]  SLOT_PCM_POINTER,
  output logic      [7:0]  CFI_DATA,
  output logic      [7:0]  CFI_MASK,
  output logic      [7:0]  PCM_MASK,
  input  wire logic        TX_STROBE,
  input  wire logic [7:0]  TX_PCM_ADDR,
  output logic             TX_VALID,
  output logic      [7:0]  TX_DRIVE_MASK
);

  // ********************************************************************
  // Declarations
  // ********************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_DONE} ssm_state_type;

  localparam int CM_W = ssm_pkg::PTR_W + ssm_pkg::CODE_W;

  ssm_state_type state;
  logic [7:0]    memory_access_data_reg;
  logic [7:0]    memory_access_addr_reg;
  logic [7:0]    memory_access_command_reg;
  logic [7:0]    cfi_subchannel_mode;
  logic          memory_access_busy_flag;
  logic          apb_write;
  logic          apb_setup;
  logic          next_hit;
  logic [31:0]   next_rdata;
  logic          cm_we;
  logic [CM_W-1:0] cm_wmask;
  logic [CM_W-1:0] cm_host_rdata;
  logic [CM_W-1:0] cm_frame_rdata;
  logic          ts_we;
  logic [3:0]    ts_frame_rdata;
  logic          slot_pipe;
  logic          tx_pipe;
  logic [7:0]    sample_pipe;
  logic [1:0]    port_pipe;
  logic [1:0]    port_mode;
  logic [7:0]    map_cfi_byte;
  logic [7:0]    map_cfi_mask;
  logic [7:0]    map_pcm_mask;
  logic          map_switched;
  logic [7:0]    next_drive_mask;

  if (SLOT_W != ssm_pkg::PTR_W) begin : g_check
    $error("ssm_top: slot address width must be 8");
  end

  // ********************************************************************
  // APB slave
  // ********************************************************************
  // Write takes effect only in the access cycle with the ready answer
  assign apb_write = CE && PSEL && PENABLE && PREADY && PWRITE;
  assign apb_setup = PSEL && !PENABLE;
  assign memory_access_busy_flag = (state != ST_IDLE);

  // Read mux and address decode, evaluated in the setup cycle
  always_comb begin
    next_hit   = 1'b1;
    next_rdata = 32'h0000_0000;
    case (PADDR)
      ssm_pkg::OFS_DATA:   next_rdata[7:0] = memory_access_data_reg;
      ssm_pkg::OFS_ADDR:   next_rdata[7:0] = memory_access_addr_reg;
      ssm_pkg::OFS_CMD:    next_rdata[7:0] = memory_access_command_reg;
      ssm_pkg::OFS_STATUS: next_rdata[ssm_pkg::STATUS_BUSY] = memory_access_busy_flag;
      ssm_pkg::OFS_MODE:   next_rdata[7:0] = cfi_subchannel_mode;
      default:             next_hit = 1'b0;
    endcase
  end

  // No wait state; ready is registered from the setup cycle so all bus outputs stay registered
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else if (CE) begin
      PREADY  <= apb_setup;
      PSLVERR <= apb_setup && !next_hit;
      if (apb_setup && !PWRITE) begin
        PRDATA <= next_rdata;
      end
    end
  end

  // ********************************************************************
  // Host registers
  // ********************************************************************
  // mode register reset 00
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      cfi_subchannel_mode <= ssm_pkg::MODE_RESET;
    end else if (apb_write && PADDR == ssm_pkg::OFS_MODE) begin
      cfi_subchannel_mode <= PWDATA[7:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      memory_access_addr_reg <= ssm_pkg::ADDR_RESET;
    end else if (apb_write && PADDR == ssm_pkg::OFS_ADDR) begin
      memory_access_addr_reg <= PWDATA[7:0];
    end
  end

  // Read results win over a host write in the completing cycle
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      memory_access_data_reg <= ssm_pkg::DATA_RESET;
    end else if (CE) begin
      if (state == ST_DONE && memory_access_command_reg == ssm_pkg::CMD_READ_DATA) begin
        memory_access_data_reg <= cm_host_rdata[CM_W-1:ssm_pkg::CODE_W];
      end else if (state == ST_DONE
                   && memory_access_command_reg == ssm_pkg::CMD_READ_CODE) begin
        memory_access_data_reg <= {4'h0, cm_host_rdata[ssm_pkg::CODE_W-1:0]};
      end else if (apb_write && PADDR == ssm_pkg::OFS_DATA) begin
        memory_access_data_reg <= PWDATA[7:0];
      end
    end
  end

  // ********************************************************************
  // Command engine
  // ********************************************************************
  // command write starts operation
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state                     <= ST_IDLE;
      memory_access_command_reg <= 8'h00;
    end else if (CE) begin
      case (state)
        ST_IDLE: begin
          // Commands written while busy are dropped
          if (apb_write && PADDR == ssm_pkg::OFS_CMD) begin
            memory_access_command_reg <= PWDATA[7:0];
            state                     <= ST_ACCESS;
          end
        end
        ST_ACCESS: state <= ST_DONE;
        ST_DONE:   state <= ST_IDLE;
        default:   state <= ST_IDLE;
      endcase
    end
  end

  // Control memory write selection
  always_comb begin
    cm_we    = 1'b0;
    cm_wmask = '0;
    if (state == ST_ACCESS) begin
      if (memory_access_command_reg[7:4] == ssm_pkg::CMD_SWITCH_HI
          && !memory_access_command_reg[3]) begin
        cm_we = 1'b1;
        if (memory_access_command_reg[3:0] == ssm_pkg::CODE_UNASSIGNED) begin
          cm_wmask = {{ssm_pkg::PTR_W{1'b0}}, {ssm_pkg::CODE_W{1'b1}}};
        end else begin
          cm_wmask = {CM_W{1'b1}};
        end
      end else if (memory_access_command_reg == ssm_pkg::CMD_DATA_ONLY) begin
        cm_we    = 1'b1;
        cm_wmask = {{ssm_pkg::PTR_W{1'b1}}, {ssm_pkg::CODE_W{1'b0}}};
      end
    end
  end

  assign ts_we = (state == ST_ACCESS) && (memory_access_command_reg == ssm_pkg::CMD_TRISTATE);

  ssm_ctrl_mem #(
    .ADDR_W (SLOT_W),
    .WORD_W (CM_W)
  ) u_control_memory (
    .clk         (CLK),
    .host_en     (CE && state == ST_ACCESS),
    .host_we     (cm_we),
    .host_wmask  (cm_wmask),
    .host_addr   (memory_access_addr_reg),
    .host_wdata  ({memory_access_data_reg, memory_access_command_reg[3:0]}),
    .host_rdata  (cm_host_rdata),
    .frame_en    (CE && SLOT_STROBE),
    .frame_addr  (SLOT_CFI_ADDR),
    .frame_rdata (cm_frame_rdata)
  );

  ssm_ctrl_mem #(
    .ADDR_W (SLOT_W),
    .WORD_W (4)
  ) u_tristate_memory (
    .clk         (CLK),
    .host_en     (CE && state == ST_ACCESS),
    .host_we     (ts_we),
    .host_wmask  (4'hF),
    .host_addr   (memory_access_addr_reg),
    .host_wdata  (memory_access_data_reg[3:0]),
    .host_rdata  (),
    .frame_en    (CE && TX_STROBE),
    .frame_addr  (TX_PCM_ADDR),
    .frame_rdata (ts_frame_rdata)
  );

  // ********************************************************************
  // Frame side
  // ********************************************************************
  // Sample and port travel alongside the memory read
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      slot_pipe   <= 1'b0;
      tx_pipe     <= 1'b0;
      sample_pipe <= 8'h00;
      port_pipe   <= 2'b00;
    end else if (CE) begin
      slot_pipe   <= SLOT_STROBE;
      tx_pipe     <= TX_STROBE;
      sample_pipe <= PCM_SAMPLE;
      port_pipe   <= SLOT_CFI_ADDR[ssm_pkg::CFI_PORT_LSB +: 2];
    end
  end

  assign port_mode = cfi_subchannel_mode[{port_pipe, 1'b0} +: 2];

  // Subslot mapping per slot
  ssm_subslot_map u_subslot_map (
    .code     (cm_frame_rdata[ssm_pkg::CODE_W-1:0]),
    .mode     (port_mode),
    .pcm_byte (sample_pipe),
    .cfi_byte (map_cfi_byte),
    .cfi_mask (map_cfi_mask),
    .pcm_mask (map_pcm_mask),
    .switched (map_switched)
  );

  // each tristate bit drives a pair
  for (genvar i = 0; i < 4; i++) begin : g_drive
    assign next_drive_mask[2*i +: 2] = {2{ts_frame_rdata[i]}};
  end

  // Registered slot results
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      SLOT_VALID       <= 1'b0;
      SLOT_SWITCHED    <= 1'b0;
      SLOT_PCM_POINTER <= 8'h00;
      CFI_DATA         <= 8'h00;
      CFI_MASK         <= 8'h00;
      PCM_MASK         <= 8'h00;
    end else if (CE) begin
      SLOT_VALID <= slot_pipe;
      if (slot_pipe) begin
        SLOT_SWITCHED    <= map_switched;
        SLOT_PCM_POINTER <= cm_frame_rdata[CM_W-1:ssm_pkg::CODE_W];
        CFI_DATA         <= map_cfi_byte;
        CFI_MASK         <= map_cfi_mask;
        PCM_MASK         <= map_pcm_mask;
      end
    end
  end

  // Transmit driver enables, high means drive
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      TX_VALID      <= 1'b0;
      TX_DRIVE_MASK <= 8'h00;
    end else if (CE) begin
      TX_VALID <= tx_pipe;
      if (tx_pipe) begin
        TX_DRIVE_MASK <= next_drive_mask;
      end
    end
  end

endmodule

`default_nettype wire

/* File: verification/ssm_top_props.sv */
// Checker of bus and lookup timing at the ports of ssm_top.
// Assumes CE stays high while traffic runs.
`timescale 1ns/100ps
`default_nettype none
module ssm_top_props (
  input wire logic       CLK,
  input wire logic       RESET_N,
  input wire logic       CE,
  input wire logic       PSEL,
  input wire logic       PENABLE,
  input wire logic [7:0] PADDR,
  input wire logic       PREADY,
  input wire logic       PSLVERR,
  input wire logic       SLOT_STROBE,
  input wire logic       SLOT_VALID,
  input wire logic       SLOT_SWITCHED,
  input wire logic [7:0] CFI_DATA,
  input wire logic [7:0] CFI_MASK,
  input wire logic [7:0] PCM_MASK,
  input wire logic       TX_STROBE,
  input wire logic       TX_VALID,
  input wire logic [7:0] TX_DRIVE_MASK
);
  // One domain; reset ends every check
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  property p_ready;
    CE && PSEL && !PENABLE |=> PREADY ##1 !PREADY;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not one cycle");
  property p_err;
    PSLVERR |-> PREADY && !(PADDR inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10});
  endproperty
  a_err: assert property (p_err) else $error("error on mapped place");
  property p_slot;
    CE && SLOT_STROBE ##1 CE |=> SLOT_VALID && $past(SLOT_STROBE, 2);
  endproperty
  a_slot: assert property (p_slot) else $error("slot answer late");
  property p_tx;
    CE && TX_STROBE ##1 CE |=> TX_VALID;
  endproperty
  a_tx: assert property (p_tx) else $error("transmit answer late");
  property p_pair;
    TX_VALID |-> TX_DRIVE_MASK == {{2{TX_DRIVE_MASK[7]}}, {2{TX_DRIVE_MASK[5]}},
                                   {2{TX_DRIVE_MASK[3]}}, {2{TX_DRIVE_MASK[1]}}};
  endproperty
  a_pair: assert property (p_pair) else $error("drive pair split");
  property p_one;
    SLOT_VALID |-> CFI_MASK inside {8'hFF, 8'hF0, 8'h0F, 8'hC0, 8'h30, 8'h0C, 8'h03, 8'h00};
  endproperty
  a_one: assert property (p_one) else $error("bad subslot place");
  property p_width;
    SLOT_VALID |-> $countones(CFI_MASK) == $countones(PCM_MASK) && (CFI_DATA & ~CFI_MASK) == 8'h00;
  endproperty
  a_width: assert property (p_width) else $error("width mismatch");
  property p_sw;
    SLOT_VALID |-> SLOT_SWITCHED == (PCM_MASK != 8'h00);
  endproperty
  a_sw: assert property (p_sw) else $error("switched flag wrong");
endmodule
bind ssm_top ssm_top_props chk (
  .CLK(CLK), .RESET_N(RESET_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
  .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR), .SLOT_STROBE(SLOT_STROBE),
  .SLOT_VALID(SLOT_VALID), .SLOT_SWITCHED(SLOT_SWITCHED), .CFI_DATA(CFI_DATA),
  .CFI_MASK(CFI_MASK), .PCM_MASK(PCM_MASK), .TX_STROBE(TX_STROBE),
  .TX_VALID(TX_VALID), .TX_DRIVE_MASK(TX_DRIVE_MASK)
);
`default_nettype wire

/* File: verification/ssm_far_model.sv */
// Frame sequencer model offering one lookup at a time.
// Assumes req is called just after a rising edge of clk.
`timescale 1ns/100ps
`default_nettype none
module ssm_far_model (
  input  wire logic       clk,
  output logic            slot_strobe,
  output logic      [7:0] slot_cfi_addr,
  output logic      [7:0] pcm_sample,
  output logic            tx_strobe,
  output logic      [7:0] tx_pcm_addr
);
  // Quiet lines at time zero
  initial begin
    slot_strobe   = 1'b0;
    tx_strobe     = 1'b0;
    slot_cfi_addr = 8'h00;
    pcm_sample    = 8'h00;
    tx_pcm_addr   = 8'h00;
  end
  // slot address with its sample, or transmit address
  // Released lines invert so a stale value never matches
  task automatic req(input logic tx, input logic [7:0] a, input logic [7:0] s);
    if (tx) begin
      tx_strobe   <= 1'b1;
      tx_pcm_addr <= a;
    end else begin
      slot_strobe   <= 1'b1;
      slot_cfi_addr <= a;
      pcm_sample    <= s;
    end
    @(posedge clk);
    slot_strobe   <= 1'b0;
    tx_strobe     <= 1'b0;
    slot_cfi_addr <= ~slot_cfi_addr;
    tx_pcm_addr   <= ~tx_pcm_addr;
    pcm_sample    <= ~pcm_sample;
  endtask
endmodule
`default_nettype wire

/* File: verification/ssm_top_tb.sv */
// Bench for ssm_top: programming commands, slot and transmit lookups.
// Assumes the far side model and a free running CE tied high.
`timescale 1ns/100ps
`default_nettype none
module ssm_top_tb;
  logic        CLK     = 1'b0;
  logic        RESET_N = 1'b0;
  logic        CE      = 1'b1;
  logic        PSEL    = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE  = 1'b0;
  logic [7:0]  PADDR   = 8'h00;
  logic [31:0] PWDATA  = 32'h0;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, SLOT_STROBE, SLOT_VALID, SLOT_SWITCHED, TX_STROBE, TX_VALID;
  logic [7:0]  SLOT_CFI_ADDR, PCM_SAMPLE, SLOT_PCM_POINTER, CFI_DATA;
  logic [7:0]  CFI_MASK, PCM_MASK, TX_PCM_ADDR, TX_DRIVE_MASK;
  int          num_errors = 0;
  int          n_tests    = 0;
  // 200 MHz clock
  always #2.5 CLK = ~CLK;
  ssm_top dut (
    .CLK(CLK), .RESET_N(RESET_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .SLOT_STROBE(SLOT_STROBE),
    .SLOT_CFI_ADDR(SLOT_CFI_ADDR), .PCM_SAMPLE(PCM_SAMPLE), .SLOT_VALID(SLOT_VALID),
    .SLOT_SWITCHED(SLOT_SWITCHED), .SLOT_PCM_POINTER(SLOT_PCM_POINTER),
    .CFI_DATA(CFI_DATA), .CFI_MASK(CFI_MASK), .PCM_MASK(PCM_MASK),
    .TX_STROBE(TX_STROBE), .TX_PCM_ADDR(TX_PCM_ADDR), .TX_VALID(TX_VALID),
    .TX_DRIVE_MASK(TX_DRIVE_MASK)
  );
  ssm_far_model far (
    .clk(CLK), .slot_strobe(SLOT_STROBE), .slot_cfi_addr(SLOT_CFI_ADDR),
    .pcm_sample(PCM_SAMPLE), .tx_strobe(TX_STROBE), .tx_pcm_addr(TX_PCM_ADDR)
  );
  // Verdict and end of run
  task automatic give_verdict;
    if (num_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // A wait that ran out counts as a mismatch
  task automatic hang;
    num_errors++;
    give_verdict();
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One bus transfer; request held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge CLK);
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    r = PRDATA;
    e = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    if (n >= 20) hang();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, r, x);
  endtask
  // Load data and address, issue, then poll busy
  task automatic cmd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c);
    logic [31:0] r;
    logic        e;
    int          k;
    wr(ssm_pkg::OFS_DATA, 32'(d));
    wr(ssm_pkg::OFS_ADDR, 32'(a));
    wr(ssm_pkg::OFS_CMD, 32'(c));
    k = 0;
    do begin
      apb(1'b0, ssm_pkg::OFS_STATUS, 32'h0, r, e);
      k++;
    end while (r[ssm_pkg::STATUS_BUSY] !== 1'b0 && k < 20);
    if (k >= 20) hang();
  endtask
  // Lookup through the far side, wait for its answer
  task automatic look(input logic tx, input logic [7:0] a, input logic [7:0] s);
    int n;
    far.req(tx, a, s);
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while ((tx ? TX_VALID : SLOT_VALID) !== 1'b1 && n < 10);
    if (n >= 10) hang();
  endtask
  // Expected {pcm mask, cfi mask, cfi data} for code, port mode, sample
  function automatic logic [23:0] expmap(input logic [3:0] c, input logic [1:0] m,
                                         input logic [7:0] s);
    logic [7:0] pm;
    logic [7:0] cm;
    int         pl;
    int         cl;
    pm = 8'h00;
    cm = 8'h00;
    pl = 0;
    cl = 0;
    if (c == 4'h1) begin
      pm = 8'hFF;
      cm = 8'hFF;
    end else if (c[3:1] == 3'b001) begin
      pl = c[0] ? 4 : 0;
      cl = m[0] ? 0 : 4;
      pm = 8'h0F << pl;
      cm = 8'h0F << cl;
    end else if (c[3:2] == 2'b01) begin
      pl = 2 * c[1:0];
      cl = 6 - 2 * m;
      pm = 8'h03 << pl;
      cm = 8'h03 << cl;
    end
    return {pm, cm, 8'(((s & pm) >> pl) << cl)};
  endfunction
  initial begin
    logic [7:0]  a;
    logic [7:0]  ptr;
    logic [7:0]  d;
    logic [31:0] r;
    logic        e;
    logic [3:0]  nib [4];
    nib = '{4'hF, 4'h0, 4'h5, 4'hA};
    repeat (16) @(posedge CLK);
    RESET_N <= 1'b1;
    // mode reset, then ports 3..0 as 10,01,11,00
    rd(ssm_pkg::OFS_MODE, 32'h0, "mode");
    wr(ssm_pkg::OFS_MODE, 32'h9C);
    rd(ssm_pkg::OFS_MODE, 32'h9C, "mode");
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk("err", 32'(e), 32'h1);
    chk("unmapped", r, 32'h0);
    for (int c = 1; c < 8; c++) begin
      for (int p = 0; p < 4; p++) begin
        a   = 8'(c * 8 + p * 2);
        ptr = 8'(c * 16 + p + 1);
        d   = 8'(c * 37 + p * 91);
        cmd(a, ptr, 8'(8'h70 + c));
        cmd(a, 8'h00, ssm_pkg::CMD_READ_DATA);
        rd(ssm_pkg::OFS_DATA, 32'(ptr), "ptr");
        cmd(a, 8'h00, ssm_pkg::CMD_READ_CODE);
        rd(ssm_pkg::OFS_DATA, 32'(c), "code");
        look(1'b0, a, d);
        chk("pointer", 32'(SLOT_PCM_POINTER), 32'(ptr));
        chk("switched", 32'(SLOT_SWITCHED), 32'h1);
        chk("maps", {8'h0, PCM_MASK, CFI_MASK, CFI_DATA},
            32'(expmap(4'(c), 2'(8'h9C >> (2 * p)), d)));
      end
    end
    // pointer rewrite keeps code; unknown command is harmless
    a = 8'h1A;
    cmd(a, 8'hE5, ssm_pkg::CMD_DATA_ONLY);
    cmd(a, 8'h11, 8'h55);
    cmd(a, 8'h00, ssm_pkg::CMD_READ_CODE);
    rd(ssm_pkg::OFS_DATA, 32'h3, "code");
    cmd(a, 8'h77, 8'h70);
    cmd(a, 8'h00, ssm_pkg::CMD_READ_CODE);
    rd(ssm_pkg::OFS_DATA, 32'h0, "code");
    look(1'b0, a, 8'hA5);
    chk("idle", 32'({SLOT_SWITCHED, PCM_MASK, CFI_MASK}), 32'h0);
    chk("kept", 32'(SLOT_PCM_POINTER), 32'hE5);
    // drive nibble, upper data bits ignored
    for (int i = 0; i < 4; i++) begin
      d = {4'h5, nib[i]};
      cmd(8'h08, d, ssm_pkg::CMD_TRISTATE);
      look(1'b1, 8'h08, 8'h00);
      chk("drive", 32'(TX_DRIVE_MASK),
          32'({{2{d[3]}}, {2{d[2]}}, {2{d[1]}}, {2{d[0]}}}));
    end
    // tristate write leaves switching field alone
    cmd(8'h08, 8'h00, ssm_pkg::CMD_READ_CODE);
    rd(ssm_pkg::OFS_DATA, 32'h1, "code");
    cmd(8'h08, 8'h00, ssm_pkg::CMD_READ_DATA);
    rd(ssm_pkg::OFS_DATA, 32'h11, "ptr");
    give_verdict();
  end
endmodule
`default_nettype wire
